// ===== common/phy_status_pkg.sv
// Constants shared by the status summary register bank.
// Assumes a 32-bit AXI4-Lite register bus and one 10 MHz clock.
package phy_status_pkg;

    // ************************************************************
    // Register map (byte addresses)
    // ************************************************************
    localparam logic [7:0] SUMMARY_OFS  = 8'h10;  // Status summary word
    localparam logic [7:0] IRQ_STAT_OFS = 8'h20;  // Sticky event bits, W1C
    localparam logic [7:0] IRQ_MASK_OFS = 8'h24;  // Event enables

    // ************************************************************
    // Summary word bit positions
    // ************************************************************
    localparam int SUM_W          = 16;  // Summary register width
    localparam int SUM_RSVD_BIT   = 15;  // Reserved, reads zero
    localparam int SUM_XOVER_BIT  = 14;  // Pairs swapped
    localparam int SUM_RXERR_BIT  = 13;  // Receive error latch
    localparam int SUM_POL_BIT    = 12;  // Inverted polarity
    localparam int SUM_FC_BIT     = 11;  // False carrier latch
    localparam int SUM_SD_BIT     = 10;  // Signal detect, latch low
    localparam int SUM_LOCK_BIT   = 9;   // Descrambler lock, latch low
    localparam int SUM_PAGE_BIT   = 8;   // Page received
    localparam int SUM_INT_BIT    = 7;   // Interrupt pending
    localparam int SUM_RF_BIT     = 6;   // Remote fault

    // ************************************************************
    // Latch-high flag indices and event bit indices
    // ************************************************************
    localparam int LH_N      = 6;  // Number of latch-high flags
    localparam int LH_RXERR  = 0;  // Receive error
    localparam int LH_POL    = 1;  // Polarity inverted
    localparam int LH_FC     = 2;  // False carrier
    localparam int LH_PAGE   = 3;  // Page received
    localparam int LH_INT    = 4;  // Interrupt pending
    localparam int LH_RF     = 5;  // Remote fault
    localparam int EV_N      = 8;  // Number of interrupt events
    localparam int EV_SDLOST = 6;  // Signal detect dropped
    localparam int EV_LKLOST = 7;  // Descrambler lock dropped

    // ************************************************************
    // Bus encodings and reset values
    // ************************************************************
    localparam logic [1:0]      RESP_OKAY   = 2'h0;   // Normal answer
    localparam logic [1:0]      RESP_SLVERR = 2'h2;   // Unmapped address
    localparam logic [EV_N-1:0] MASK_RST    = 8'h00;  // All events masked
    localparam logic [31:0]     DATA_ZERO   = 32'h0000_0000;

endpackage : phy_status_pkg

// ===== src/sticky_flag.sv
// Bank of sticky flags: a set pulse raises a flag, a clear pulse drops it.
// Assumes set and clear come from logic on the same clock as the bank.
`timescale 1ns/100ps
`default_nettype none

module sticky_flag #(
    parameter int N = 6  // Number of flags
) (
    input  wire logic         aclk,
    input  wire logic         aresetn,
    input  wire logic         ce,
    input  wire logic [N-1:0] set,
    input  wire logic [N-1:0] clr,
    output logic      [N-1:0] q
);

    // ************************************************************
    // One flip-flop per flag
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_flag
            // Set wins over a clear in the same cycle
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    q[i] <= 1'b0;
                end else if (ce) begin
                    q[i] <= set[i] | (q[i] & ~clr[i]);
                end
            end
        end
    endgenerate

endmodule : sticky_flag

`default_nettype wire

// ===== src/phy_status_summary_register.sv
// Status summary register of a 10/100 transceiver, with AXI4-Lite access.
// Assumes source flags, events and read pulses of the mirrored registers
// come from transceiver logic on aclk; aclk runs at 10 MHz.
//
// How it works
// - Top bit ignores writes, reads zero
// - Crossover bit one when pairs swapped
// - Crossover follows enable, force, live algorithm
// - Receive error latched until counter read
// - Polarity mirrored; summary read leaves it
// - False carrier latched until counter read
// - Signal detect reported with latch-low behaviour
// - Descrambler lock reported with latch-low behaviour
// - Page received kept across summary reads
// - Page received cleared by expansion read
// - Interrupt pending until status register read
// - Remote fault cleared by status read, reset
`timescale 1ns/100ps
`default_nettype none

module phy_status_summary_register
    import phy_status_pkg::*;
#(
    parameter int ADDR_W = 8  // AXI address width
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic              ce,
    // AXI4-Lite write address
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    // AXI4-Lite write data
    input  wire logic [31:0]       wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // AXI4-Lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read address
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    // AXI4-Lite read data
    output logic [31:0]            rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Crossover control and state
    input  wire logic              auto_crossover_enable,
    input  wire logic              crossover_force,
    input  wire logic              mdix_swapped,
    // Transceiver events, one-cycle pulses
    input  wire logic              rx_error_event,
    input  wire logic              polarity_inverted_event,
    input  wire logic              false_carrier_event,
    input  wire logic              page_received_event,
    input  wire logic              internal_irq_event,
    input  wire logic              remote_fault_event,
    // Medium-dependent sublayer levels
    input  wire logic              signal_detect,
    input  wire logic              descrambler_lock,
    // Reads of the mirrored registers, one-cycle pulses
    input  wire logic              rx_error_counter_reg_rd,
    input  wire logic              tenbase_status_control_reg_rd,
    input  wire logic              false_carrier_counter_reg_rd,
    input  wire logic              autoneg_expansion_reg_rd,
    input  wire logic              interrupt_status_event_reg_rd,
    input  wire logic              basic_mode_status_reg_rd,
    // Interrupt output, level
    output logic                   irq
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic              wr_go;          // Write taken this cycle
    logic              rd_go;          // Read taken this cycle
    logic              summary_rd;     // Summary word read this cycle
    logic              xover_r;        // Crossover state
    logic              xover_nxt;      // Next crossover state
    logic              sd_ll_r;        // Signal detect, latch low
    logic              lock_ll_r;      // Descrambler lock, latch low
    logic [LH_N-1:0]   lh_set;         // Latch-high set pulses
    logic [LH_N-1:0]   lh_clr;         // Latch-high clear pulses
    logic [LH_N-1:0]   lh_q;           // Latch-high flags
    logic [EV_N-1:0]   ev_set;         // Interrupt event pulses
    logic [EV_N-1:0]   ev_clr;         // W1C clear pulses
    logic [EV_N-1:0]   irq_stat;       // Sticky event bits
    logic [EV_N-1:0]   irq_mask_r;     // Event enables
    logic [SUM_W-1:0]  summary;        // Assembled summary word
    logic [31:0]       rd_word;        // Read mux output
    logic [1:0]        rd_resp;        // Read mux answer

    // ************************************************************
    // Bus handshakes
    // ************************************************************
    // Address and data taken together, only when no answer is pending
    assign awready = ce & awvalid & wvalid & ~bvalid;
    assign wready  = awready;
    assign wr_go   = awready;
    assign arready = ce & ~rvalid;
    assign rd_go   = arready & arvalid;
    assign summary_rd = rd_go & (araddr == ADDR_W'(SUMMARY_OFS));

    // Write answer; the summary word takes no write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (ce) begin
            if (wr_go) begin
                bvalid <= 1'b1;
                // Summary and event registers answer OKAY
                if (awaddr == ADDR_W'(SUMMARY_OFS) ||
                    awaddr == ADDR_W'(IRQ_STAT_OFS) ||
                    awaddr == ADDR_W'(IRQ_MASK_OFS)) begin
                    bresp <= RESP_OKAY;
                end else begin
                    bresp <= RESP_SLVERR;
                end
            end else if (bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Mask register, low byte lane only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_r <= MASK_RST;
        end else if (ce && wr_go && wstrb[0] &&
                     awaddr == ADDR_W'(IRQ_MASK_OFS)) begin
            irq_mask_r <= wdata[EV_N-1:0];
        end
    end

    // W1C pulses for the event register
    always_comb begin
        ev_clr = '0;
        if (wr_go && wstrb[0] && awaddr == ADDR_W'(IRQ_STAT_OFS)) begin
            ev_clr = wdata[EV_N-1:0];
        end
    end

    // ************************************************************
    // Crossover status
    // ************************************************************
    // Forced swap, live algorithm state, or normal pairs
    always_comb begin
        if (crossover_force) begin
            xover_nxt = 1'b1;
        end else if (auto_crossover_enable) begin
            xover_nxt = mdix_swapped;
        end else begin
            xover_nxt = 1'b0;
        end
    end

    // Registered so the read word is glitch free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xover_r <= 1'b0;
        end else if (ce) begin
            xover_r <= xover_nxt;
        end
    end

    // ************************************************************
    // Latch-high flags
    // ************************************************************
    // Each flag raised by its event, dropped by its owner's read
    always_comb begin
        lh_set           = '0;
        lh_clr           = '0;
        lh_set[LH_RXERR] = rx_error_event;
        lh_clr[LH_RXERR] = rx_error_counter_reg_rd;
        lh_set[LH_POL]   = polarity_inverted_event;
        lh_clr[LH_POL]   = tenbase_status_control_reg_rd;
        lh_set[LH_FC]    = false_carrier_event;
        lh_clr[LH_FC]    = false_carrier_counter_reg_rd;
        lh_set[LH_PAGE]  = page_received_event;
        lh_clr[LH_PAGE]  = autoneg_expansion_reg_rd;
        lh_set[LH_INT]   = internal_irq_event;
        lh_clr[LH_INT]   = interrupt_status_event_reg_rd;
        lh_set[LH_RF]    = remote_fault_event;
        lh_clr[LH_RF]    = basic_mode_status_reg_rd;
    end

    // Flag bank; summary reads are not a clear source
    sticky_flag #(
        .N       (LH_N)
    ) u_latch_high (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .set     (lh_set),
        .clr     (lh_clr),
        .q       (lh_q)
    );

    // ************************************************************
    // Latch-low levels
    // ************************************************************
    // A drop is held until the summary is read, then the live level
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sd_ll_r   <= 1'b0;
            lock_ll_r <= 1'b0;
        end else if (ce) begin
            if (summary_rd) begin
                sd_ll_r   <= signal_detect;
                lock_ll_r <= descrambler_lock;
            end else begin
                sd_ll_r   <= sd_ll_r & signal_detect;
                lock_ll_r <= lock_ll_r & descrambler_lock;
            end
        end
    end

    // ************************************************************
    // Interrupt events
    // ************************************************************
    // Latch-high events, plus a drop seen while the latch reads one
    always_comb begin
        ev_set            = '0;
        ev_set[LH_N-1:0]  = lh_set;
        ev_set[EV_SDLOST] = sd_ll_r & ~signal_detect;
        ev_set[EV_LKLOST] = lock_ll_r & ~descrambler_lock;
    end

    // Sticky event bits, write one to clear
    sticky_flag #(
        .N       (EV_N)
    ) u_event (
        .aclk    (aclk),
        .aresetn (aresetn),
        .ce      (ce),
        .set     (ev_set),
        .clr     (ev_clr),
        .q       (irq_stat)
    );

    // Level output while any enabled event is pending
    assign irq = |(irq_stat & irq_mask_r);

    // ************************************************************
    // Read path
    // ************************************************************
    // Assemble the summary word; unused low bits read zero
    always_comb begin
        summary                = '0;
        summary[SUM_RSVD_BIT]  = 1'b0;
        summary[SUM_XOVER_BIT] = xover_r;
        summary[SUM_RXERR_BIT] = lh_q[LH_RXERR];
        summary[SUM_POL_BIT]   = lh_q[LH_POL];
        summary[SUM_FC_BIT]    = lh_q[LH_FC];
        summary[SUM_SD_BIT]    = sd_ll_r;
        summary[SUM_LOCK_BIT]  = lock_ll_r;
        summary[SUM_PAGE_BIT]  = lh_q[LH_PAGE];
        summary[SUM_INT_BIT]   = lh_q[LH_INT];
        summary[SUM_RF_BIT]    = lh_q[LH_RF];
    end

    // Address decode for reads
    always_comb begin
        rd_word = DATA_ZERO;
        rd_resp = RESP_OKAY;
        if (araddr == ADDR_W'(SUMMARY_OFS)) begin
            rd_word[SUM_W-1:0] = summary;
        end else if (araddr == ADDR_W'(IRQ_STAT_OFS)) begin
            rd_word[EV_N-1:0] = irq_stat;
        end else if (araddr == ADDR_W'(IRQ_MASK_OFS)) begin
            rd_word[EV_N-1:0] = irq_mask_r;
        end else begin
            rd_resp = RESP_SLVERR;
        end
    end

    // Read answer one cycle after the address is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= DATA_ZERO;
            rresp  <= RESP_OKAY;
        end else if (ce) begin
            if (rd_go) begin
                rvalid <= 1'b1;
                rdata  <= rd_word;
                rresp  <= rd_resp;
            end else if (rready) begin
                rvalid <= 1'b0;
            end
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Summary read taken
    sequence rd_summary_s;
        summary_rd;
    endsequence

    // Summary write taken while no flag is being set or cleared
    sequence wr_summary_s;
        wr_go && awaddr == ADDR_W'(SUMMARY_OFS) && !(|lh_set) && !(|lh_clr);
    endsequence

    rsvd_zero_a: assert property (
        rd_summary_s |=> rvalid && rdata[SUM_RSVD_BIT] == 1'b0)
        else $error("reserved summary bit read as one");

    xover_map_a: assert property (
        ce && !crossover_force && auto_crossover_enable
        |=> xover_r == $past(mdix_swapped))
        else $error("crossover bit does not follow algorithm");

    xover_force_a: assert property (
        ce && crossover_force ##1 rd_summary_s
        |=> rdata[SUM_XOVER_BIT])
        else $error("forced swap not reported");

    rxerr_hold_a: assert property (
        ce && lh_q[LH_RXERR] && !rx_error_counter_reg_rd
        |=> lh_q[LH_RXERR])
        else $error("receive error latch lost without counter read");

    pol_keep_a: assert property (
        rd_summary_s and (lh_q[LH_POL] && !tenbase_status_control_reg_rd)
        |=> lh_q[LH_POL] && rdata[SUM_POL_BIT])
        else $error("summary read disturbed polarity");

    fc_clear_a: assert property (
        ce && false_carrier_counter_reg_rd && !false_carrier_event
        |=> !lh_q[LH_FC])
        else $error("false carrier latch not cleared");

    sd_low_a: assert property (
        ce && !signal_detect ##1 (!summary_rd)[*2] |=> !sd_ll_r)
        else $error("signal detect drop not held");

    lock_low_a: assert property (
        ce && !descrambler_lock ##1 (!summary_rd)[*2]
        ##1 rd_summary_s |=> rdata[SUM_LOCK_BIT] == 1'b0)
        else $error("lock drop missed by next read");

    page_clear_a: assert property (
        ce && autoneg_expansion_reg_rd && !page_received_event
        |=> !lh_q[LH_PAGE])
        else $error("page received not cleared");

    int_set_a: assert property (
        ce && internal_irq_event |=> lh_q[LH_INT] && irq_stat[LH_INT])
        else $error("interrupt pending not raised");

    rf_clear_a: assert property (
        ce && basic_mode_status_reg_rd && !remote_fault_event
        |=> !lh_q[LH_RF])
        else $error("remote fault not cleared");

    ro_write_a: assert property (
        wr_summary_s |=> bvalid && bresp == RESP_OKAY && $stable(lh_q))
        else $error("summary write had an effect");

endmodule : phy_status_summary_register

`default_nettype wire

// ===== verif/mgmt_master.sv
// Management controller model: an AXI4-Lite master with bounded waits.
// Assumes a slave on aclk; each task reports whether its answer came.
`timescale 1ns/100ps
`default_nettype none

module mgmt_master (
    input  wire logic        aclk,
    output logic      [7:0]  awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic      [31:0] wdata,
    output logic      [3:0]  wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    output logic      [7:0]  araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    // ****************************************************
    // Idle bus at time zero
    // ****************************************************
    initial begin
        {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
        {araddr, arvalid, rready} = '0;
    end

    // One write: address and data offered together, then the response
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      output logic [1:0] r, output bit ok);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        do @(posedge aclk); while (!(awready && wready) && ++n < 64);
        awvalid <= 1'b0;
        wvalid  <= 1'b0;
        bready  <= 1'b1;
        do @(posedge aclk); while (!bvalid && ++n < 128);
        r = bresp;
        bready <= 1'b0;
        ok = (n < 128);
    endtask : wr

    // One read: ready held from the request until data is seen
    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r, output bit ok);
        int n;
        n = 0;
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do @(posedge aclk); while (!arready && ++n < 64);
        arvalid <= 1'b0;
        do @(posedge aclk); while (!rvalid && ++n < 128);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        ok = (n < 128);
    endtask : rd
endmodule : mgmt_master
`default_nettype wire

// ===== verif/test_phy_status_summary_register.sv
// Self-checking bench for the status summary register bank.
// Assumes the management controller model in mgmt_master.
`timescale 1ns/100ps
`default_nettype none

module test_phy_status_summary_register;
    import phy_status_pkg::*;
    logic        aclk = 1'b0;  // 10 MHz clock
    logic        aresetn = 1'b0;
    logic        ce = 1'b1;    // Clock enable, low only for the frozen flag check
    logic        xf = 1'b0;    // Crossover force
    logic        xe = 1'b0;    // Crossover enable
    logic        xs = 1'b0;    // Pairs swapped
    logic        sd = 1'b1;    // Signal detect level
    logic        lk = 1'b1;    // Descrambler lock level
    logic [5:0]  ev = 6'h00;   // Event pulses
    logic [5:0]  clr = 6'h00;  // Owning register read pulses
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic        awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, irq;
    int          n_fail = 0;
    int          comparisons = 0;
    int          i;
    int          pos[6] = '{SUM_RXERR_BIT, SUM_POL_BIT, SUM_FC_BIT,
                            SUM_PAGE_BIT, SUM_INT_BIT, SUM_RF_BIT};
    logic [3:0]  xt[4] = '{4'b1001, 4'b0111, 4'b0100, 4'b0010};

    always #50 aclk = ~aclk;

    phy_status_summary_register i_phy_status_summary_register (
        .aclk, .aresetn, .ce, .awaddr, .awvalid, .awready, .wdata, .wstrb,
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
        .arready, .rdata, .rresp, .rvalid, .rready, .irq,
        .auto_crossover_enable(xe), .crossover_force(xf), .mdix_swapped(xs),
        .rx_error_event(ev[0]), .polarity_inverted_event(ev[1]),
        .false_carrier_event(ev[2]), .page_received_event(ev[3]),
        .internal_irq_event(ev[4]), .remote_fault_event(ev[5]),
        .signal_detect(sd), .descrambler_lock(lk),
        .rx_error_counter_reg_rd(clr[0]),
        .tenbase_status_control_reg_rd(clr[1]),
        .false_carrier_counter_reg_rd(clr[2]),
        .autoneg_expansion_reg_rd(clr[3]),
        .interrupt_status_event_reg_rd(clr[4]),
        .basic_mode_status_reg_rd(clr[5]));

    mgmt_master i_mgmt_master (
        .aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
        .rdata, .rresp, .rvalid, .rready);

    // ****************************************************
    // Helpers
    // ****************************************************
    task automatic chk(string nm, logic [31:0] s, logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask : chk

    task close_out;
        if (n_fail == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : close_out

    task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] er);
        logic [1:0] r;
        bit         ok;
        i_mgmt_master.wr(a, d, r, ok);
        chk("write done", ok, 1'b1);
        if (!ok)
            close_out();
        chk("bresp", r, er);
    endtask : wr

    task automatic rd(logic [7:0] a, output logic [31:0] d,
                      input logic [1:0] er);
        logic [1:0] r;
        bit         ok;
        i_mgmt_master.rd(a, d, r, ok);
        chk("read done", ok, 1'b1);
        if (!ok)
            close_out();
        chk("rresp", r, er);
    endtask : rd

    // One-cycle event and clear pulses
    task pulse(logic [5:0] e, logic [5:0] c);
        @(posedge aclk);
        ev  <= e;
        clr <= c;
        @(posedge aclk);
        ev  <= 6'h00;
        clr <= 6'h00;
    endtask : pulse

    // ****************************************************
    // Main sequence
    // ****************************************************
    initial begin
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd(IRQ_MASK_OFS, v, RESP_OKAY);
        chk("mask reset", v, 32'h0);
        rd(SUMMARY_OFS, v, RESP_OKAY);
        chk("first read", v, 32'h0);
        rd(SUMMARY_OFS, v, RESP_OKAY);
        chk("live read", v, 32'h0600);
        for (i = 0; i < 2; i++) begin
            @(posedge aclk);
            {sd, lk} <= i ? 2'b10 : 2'b01;
            @(posedge aclk);
            {sd, lk} <= 2'b11;
            @(posedge aclk);
            rd(SUMMARY_OFS, v, RESP_OKAY);
            chk("latch low", v[10:9], i ? 2'b10 : 2'b01);
            rd(SUMMARY_OFS, v, RESP_OKAY);
            chk("relive", v[10:9], 2'b11);
        end
        rd(IRQ_STAT_OFS, v, RESP_OKAY);
        chk("drop events", v, 32'hC0);
        for (i = 0; i < 4; i++) begin
            @(posedge aclk);
            {xf, xe, xs} <= xt[i][3:1];
            repeat (2) @(posedge aclk);
            rd(SUMMARY_OFS, v, RESP_OKAY);
            chk("crossover", v[SUM_XOVER_BIT], xt[i][0]);
        end
        for (i = 0; i < 6; i++) begin
            pulse(6'h01 << i, 6'h00);
            rd(SUMMARY_OFS, v, RESP_OKAY);
            chk("flag set", v[pos[i]], 1'b1);
            rd(SUMMARY_OFS, v, RESP_OKAY);
            chk("flag kept", v[pos[i]], 1'b1);
            pulse(6'h00, 6'h01 << i);
            rd(SUMMARY_OFS, v, RESP_OKAY);
            chk("flag clear", v[pos[i]], 1'b0);
        end
        pulse(6'h01, 6'h00);
        for (i = 0; i < 2; i++) begin
            wr(SUMMARY_OFS, i ? 32'h0 : 32'hFFFF_FFFF, RESP_OKAY);
            rd(SUMMARY_OFS, v, RESP_OKAY);
            chk("after write", v, 32'h2600);
        end
        chk("irq masked", irq, 1'b0);
        wr(IRQ_MASK_OFS, 32'h01, RESP_OKAY);
        chk("irq unmasked", irq, 1'b1);
        wr(IRQ_STAT_OFS, 32'hFF, RESP_OKAY);
        rd(IRQ_STAT_OFS, v, RESP_OKAY);
        chk("status cleared", v, 32'h0);
        chk("irq cleared", irq, 1'b0);
        pulse(6'h01, 6'h00);
        rd(IRQ_STAT_OFS, v, RESP_OKAY);
        chk("status again", v, 32'h01);
        chk("irq again", irq, 1'b1);
        wr(IRQ_MASK_OFS, 32'h0, RESP_OKAY);
        chk("irq remasked", irq, 1'b0);
        rd(8'h30, v, RESP_SLVERR);
        chk("unmapped data", v, 32'h0);
        wr(8'h30, 32'h0, RESP_SLVERR);
        ce <= 1'b0;
        pulse(6'h04, 6'h00);
        ce <= 1'b1;
        rd(SUMMARY_OFS, v, RESP_OKAY);
        chk("frozen flag", v[SUM_FC_BIT], 1'b0);
        pulse(6'h20, 6'h00);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        rd(SUMMARY_OFS, v, RESP_OKAY);
        chk("fault reset", v[SUM_RF_BIT], 1'b0);
        close_out();
    end
endmodule : test_phy_status_summary_register
`default_nettype wire
